/* File: psio_defines.svh */
// constants for the single-cycle i/o port between core and user logic
`ifndef PSIO_DEFINES_SVH
`define PSIO_DEFINES_SVH
`define PSIO_ADDR_W 12
`define PSIO_DATA_W 32
`define PSIO_LED_W 4
`define PSIO_BTN_W 4
`define PSIO_LED_ADDR 12'h000
`define PSIO_BTN_ADDR 12'h001
`define PSIO_ZERO_WORD 32'h00000000
`define PSIO_ZERO_ADDR 12'h000
`endif

/* File: psio_pkg.sv */
// types shared by both ends of the single-cycle i/o port
package psio_pkg;
    typedef enum logic [1:0] {
        PSIO_IDLE = 2'b00,
        PSIO_WAIT = 2'b01
    } psio_rd_state_t;
endpackage

/* File: psio_if.sv */
// interface joining the core end and the user-logic end
`timescale 1ns/1ps
`default_nettype none
`include "psio_defines.svh"
interface psio_if (
    input wire logic local_iface_clock
);
    logic single_read_strobe;
    logic [`PSIO_ADDR_W-1:0] single_read_addr;
    logic [`PSIO_DATA_W-1:0] single_read_word;
    logic single_read_valid;
    logic single_write_strobe;
    logic [`PSIO_ADDR_W-1:0] single_write_addr;
    logic [`PSIO_DATA_W-1:0] single_write_data;

    modport core (
        input local_iface_clock,
        output single_read_strobe,
        output single_read_addr,
        input single_read_word,
        input single_read_valid,
        output single_write_strobe,
        output single_write_addr,
        output single_write_data
    );
    modport user (
        input local_iface_clock,
        input single_read_strobe,
        input single_read_addr,
        output single_read_word,
        output single_read_valid,
        input single_write_strobe,
        input single_write_addr,
        input single_write_data
    );
endinterface
`default_nettype wire

/* File: psio_core_end.sv */
// core end: turns host requests into single-cycle strobed word accesses
// Function
// - read strobe with word address
// - user returns word with valid
// - write strobe with word address
// - core drives write word, user stores
// - write strobe, address, data leave in the same cycle
// - read address twelve bits, word units
// - write address twelve bits, word units
// - everything on core local clock
// - user drives leds, returns buttons
`timescale 1ns/1ps
`default_nettype none
`include "psio_defines.svh"
module psio_core_end
    import psio_pkg::*;
#(
    // word address and data widths
    parameter int ADDR_W = `PSIO_ADDR_W,
    parameter int DATA_W = `PSIO_DATA_W
)
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // link toward user logic
    psio_if.core link,
    // host read request side
    input wire logic host_rd_req,
    input wire logic [ADDR_W-1:0] host_rd_addr,
    output logic host_rd_busy,
    output logic host_rd_done,
    output logic [DATA_W-1:0] host_rd_word,
    // host write request side
    input wire logic host_wr_req,
    input wire logic [ADDR_W-1:0] host_wr_addr,
    input wire logic [DATA_W-1:0] host_wr_data
);
    // sequencer state and host busy flag
    psio_rd_state_t state_r, state_nxt;
    logic busy_r, busy_nxt;

    // read strobe and word address toward user logic
    logic rd_stb_r, rd_stb_nxt;
    logic [ADDR_W-1:0] rd_addr_r, rd_addr_nxt;

    // done pulse toward the host
    logic done_r, done_nxt;

    // answer word held for the host
    logic [DATA_W-1:0] word_r, word_nxt;

    // write strobe toward user logic
    logic wr_stb_r, wr_stb_nxt;

    // write address and data toward user logic
    logic [ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
    logic [DATA_W-1:0] wr_data_r, wr_data_nxt;
    // read events decoded from state and link
    logic rd_take;
    logic rd_answer;

    // link outputs straight from flops
    assign link.single_read_strobe = rd_stb_r;
    assign link.single_read_addr = rd_addr_r;
    assign link.single_write_strobe = wr_stb_r;
    assign link.single_write_addr = wr_addr_r;
    assign link.single_write_data = wr_data_r;
    // host outputs straight from flops
    assign host_rd_busy = busy_r;
    assign host_rd_done = done_r;
    assign host_rd_word = word_r;

    // a read is taken only while idle, answered only while waiting
    always_comb begin
        rd_take = 1'b0;
        rd_answer = 1'b0;
        case (state_r)
            PSIO_IDLE: begin
                rd_take = host_rd_req;
            end
            PSIO_WAIT: begin
                rd_answer = link.single_read_valid;
            end
            default: begin
                rd_answer = 1'b0;
            end
        endcase
    end

    // sequencer: busy rises with the strobe, falls with done
    always_comb begin
        state_nxt = state_r;
        busy_nxt = busy_r;
        case (state_r)
            PSIO_IDLE: begin
                if (rd_take) begin
                    state_nxt = PSIO_WAIT;
                    busy_nxt = 1'b1;
                end
            end
            PSIO_WAIT: begin
                if (rd_answer) begin
                    state_nxt = PSIO_IDLE;
                    busy_nxt = 1'b0;
                end
            end
            default: begin
                state_nxt = PSIO_IDLE;
                busy_nxt = 1'b0;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= PSIO_IDLE;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            busy_r <= busy_nxt;
        end
    end

    // read strobe one cycle, address held until next read
    always_comb begin
        rd_stb_nxt = rd_take;
        rd_addr_nxt = rd_addr_r;
        if (rd_take) begin
            rd_addr_nxt = host_rd_addr;
        end
    end

    // read request registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rd_stb_r <= 1'b0;
            rd_addr_r <= '0;
        end else begin
            rd_stb_r <= rd_stb_nxt;
            rd_addr_r <= rd_addr_nxt;
        end
    end

    // one done pulse per answered read
    always_comb begin
        done_nxt = rd_answer;
    end

    // done register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            done_r <= 1'b0;
        end else begin
            done_r <= done_nxt;
        end
    end

    // answer word taken with valid, held until the next answer
    always_comb begin
        word_nxt = word_r;
        if (rd_answer) begin
            word_nxt = link.single_read_word;
        end
    end

    // answer word register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            word_r <= '0;
        end else begin
            word_r <= word_nxt;
        end
    end

    // one write strobe per host write cycle
    always_comb begin
        wr_stb_nxt = host_wr_req;
    end

    // write strobe register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wr_stb_r <= 1'b0;
        end else begin
            wr_stb_r <= wr_stb_nxt;
        end
    end

    // address and data leave with the strobe, held until next write
    always_comb begin
        wr_addr_nxt = wr_addr_r;
        wr_data_nxt = wr_data_r;
        if (host_wr_req) begin
            wr_addr_nxt = host_wr_addr;
            wr_data_nxt = host_wr_data;
        end
    end

    // write payload registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wr_addr_r <= '0;
            wr_data_r <= '0;
        end else begin
            wr_addr_r <= wr_addr_nxt;
            wr_data_r <= wr_data_nxt;
        end
    end
endmodule
`default_nettype wire

/* File: psio_user_end.sv */
// user end: leds written by host, buttons read back by host
`timescale 1ns/1ps
`default_nettype none
`include "psio_defines.svh"
module psio_user_end
    import psio_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // link toward the core
    psio_if.user link,
    // board pins
    output logic [`PSIO_LED_W-1:0] led,
    input wire logic [`PSIO_BTN_W-1:0] button
);
    logic [`PSIO_BTN_W-1:0] btn_s1_r, btn_s2_r;
    logic [`PSIO_LED_W-1:0] led_r, led_nxt;
    logic val_r, val_nxt;
    logic [`PSIO_DATA_W-1:0] word_r, word_nxt;

    assign led = led_r;
    assign link.single_read_valid = val_r;
    assign link.single_read_word = word_r;

    // answer reads, take writes
    always_comb begin
        led_nxt = led_r;
        val_nxt = 1'b0;
        word_nxt = word_r;
        if (link.single_write_strobe &&
            link.single_write_addr == `PSIO_LED_ADDR) begin
            led_nxt = link.single_write_data[`PSIO_LED_W-1:0];
        end
        if (link.single_read_strobe) begin
            val_nxt = 1'b1;
            if (link.single_read_addr == `PSIO_BTN_ADDR) begin
                word_nxt = {{(`PSIO_DATA_W-`PSIO_BTN_W){1'b0}}, btn_s2_r};
            end else if (link.single_read_addr == `PSIO_LED_ADDR) begin
                word_nxt = {{(`PSIO_DATA_W-`PSIO_LED_W){1'b0}}, led_r};
            end else begin
                word_nxt = `PSIO_ZERO_WORD;
            end
        end
    end

    // registers on the core clock; buttons synchronised twice
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            btn_s1_r <= '0;
            btn_s2_r <= '0;
            led_r <= '0;
            val_r <= 1'b0;
            word_r <= `PSIO_ZERO_WORD;
        end else begin
            btn_s1_r <= button;
            btn_s2_r <= btn_s1_r;
            led_r <= led_nxt;
            val_r <= val_nxt;
            word_r <= word_nxt;
        end
    end
endmodule
`default_nettype wire

/* File: psio_properties.sv */
// checks on the link between core end and user end
`timescale 1ns/1ps
`default_nettype none
module psio_properties (
    // clock and reset
    input wire logic local_iface_clock,
    input wire logic reset_n,
    // link
    input wire logic single_read_strobe,
    input wire logic [11:0] single_read_addr,
    input wire logic [31:0] single_read_word,
    input wire logic single_read_valid,
    input wire logic single_write_strobe,
    input wire logic [11:0] single_write_addr,
    input wire logic [31:0] single_write_data
);
    // link clock, quiet in reset
    default clocking @(posedge local_iface_clock); endclocking
    default disable iff (!reset_n);
    // read handshake and write hold
    a_valid_late: assert property (single_read_strobe |=>
        single_read_valid) else $error("valid late");
    a_valid_once: assert property (single_read_valid |=>
        !single_read_valid) else $error("valid long");
    a_valid_cause: assert property (single_read_valid |->
        $past(single_read_strobe)) else $error("valid alone");
    a_read_gap: assert property (single_read_strobe |=>
        !single_read_strobe [*2]) else $error("strobe gap");
    a_raddr_hold: assert property (single_read_valid |->
        $stable(single_read_addr)) else $error("addr moved");
    a_wdata_hold: assert property (!single_write_strobe |->
        $stable(single_write_data)) else $error("data moved");
    a_waddr_hold: assert property (!single_write_strobe |->
        $stable(single_write_addr)) else $error("waddr moved");
    a_word_narrow: assert property (single_read_valid |->
        single_read_word[31:4] == 28'h0) else $error("high bits");
    a_word_unmapped: assert property (single_read_valid &&
        single_read_addr > 12'h001 |-> !single_read_word) else $error("map");
    // main traffic seen
    cover property (single_read_valid && single_read_addr == 12'h001);
    cover property (single_write_strobe && single_write_data != 32'h0);
    cover property (single_read_valid && single_read_word != 32'h0);
endmodule
`default_nettype wire

/* File: pcie_single_cycle_io_port_tb.sv */
// bench joining core end and user end
`timescale 1ns/1ps
`default_nettype none
module pcie_single_cycle_io_port_tb;
    logic clock = 1'b0, reset_n = 1'b0, host_rd_req = 1'b0;
    logic host_wr_req = 1'b0, host_rd_busy, host_rd_done;
    logic [11:0] host_rd_addr = 12'h000, host_wr_addr = 12'h000;
    logic [31:0] host_wr_data = 32'h00000000, host_rd_word;
    logic [3:0] led, lm = 4'h0, button = 4'h0;
    integer seed = 90, mismatches = 0, checked = 0, i;
    // 25 MHz clock
    always #20 clock = ~clock;
    psio_if k (.local_iface_clock(clock));
    psio_core_end i_psio_core_end (.clock(clock), .reset_n(reset_n),
        .link(k), .host_rd_req(host_rd_req), .host_rd_addr(host_rd_addr),
        .host_rd_busy(host_rd_busy), .host_rd_done(host_rd_done),
        .host_rd_word(host_rd_word), .host_wr_req(host_wr_req),
        .host_wr_addr(host_wr_addr), .host_wr_data(host_wr_data));
    psio_user_end i_psio_user_end (.clock(clock), .reset_n(reset_n),
        .link(k), .led(led), .button(button));
    psio_properties i_psio_properties (.local_iface_clock(clock), .reset_n,
        .single_read_strobe(k.single_read_strobe),
        .single_read_addr(k.single_read_addr),
        .single_read_word(k.single_read_word),
        .single_read_valid(k.single_read_valid),
        .single_write_strobe(k.single_write_strobe),
        .single_write_addr(k.single_write_addr),
        .single_write_data(k.single_write_data));
    // compare and count
    task chk(input logic [63:0] g, e, input string w);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s exp %h got %h", w, e, g);
        end
    endtask
    // verdict
    task test_done;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // expected read word
    function logic [31:0] ew(input logic [11:0] a);
        return a > 12'h001 ? 32'h0 : {28'h0, a[0] ? button : lm};
    endfunction
    // write a word, then read the same address back
    task op(input logic [11:0] a, input logic [31:0] d);
        host_wr_req = 1'b1;
        host_wr_addr = a;
        host_wr_data = d;
        @(posedge clock) #1;
        chk(k.single_write_strobe, 1'b1, "wstb");
        chk(k.single_write_addr, a, "waddr");
        chk(k.single_write_data, d, "wdata");
        host_wr_req = 1'b0;
        host_rd_req = 1'b1;
        host_rd_addr = a;
        if (a == 12'h000) lm = d[3:0];
        @(posedge clock) #1;
        chk({k.single_read_strobe, host_rd_busy}, 2'b11, "rd");
        chk(k.single_read_addr, a, "raddr");
        chk(led, lm, "led");
        // request left high while busy must be refused
        @(posedge clock) #1;
        chk({k.single_read_strobe, host_rd_busy}, 2'b01, "refused");
        @(posedge clock) #1;
        chk({host_rd_done, host_rd_word}, {1'b1, ew(a)}, "ans");
        chk(host_rd_busy, 1'b0, "idle");
        host_rd_req = 1'b0;
    endtask
    // reset, one all-ones corner word, then random traffic
    initial begin
        repeat (2) @(posedge clock);
        #1 reset_n = 1'b1;
        chk(led, 4'h0, "led");
        op(12'hFFF, 32'hFFFFFFFF);
        for (i = 0; i < 40; i++) begin
            button = 4'($random(seed));
            op(12'($random(seed)) & 12'h003, $random(seed));
        end
        test_done;
    end
    // hang guard
    initial begin
        #20000;
        mismatches++;
        test_done;
    end
endmodule
`default_nettype wire
